// ---- sim/ics_bus_master_model.sv ----
// behavioural two-wire bus master facing the clock-stretch block
// assumes open-drain lines with pull-ups resolved by the bench
module ics_bus_master_model (
  // resolved bus levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // pull-down requests
  output logic      o_scl_low,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  // one 125 ns bit; a slave holding scl low stalls the high phase
  task bit_io(input logic b, output logic r);
    o_sda_low = !b;
    #62.5 o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #40 r = i_sda;
    #22.5 o_scl_low = 1'b1;
  endtask : bit_io

  task start();
    o_sda_low = 1'b1;
    #62.5 o_scl_low = 1'b1;
  endtask : start

  task stop();
    o_sda_low = 1'b1;
    #62.5 o_scl_low = 1'b0;
    wait (i_scl === 1'b1);
    #62.5 o_sda_low = 1'b0;
    #62.5;
  endtask : stop

  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte

  task rbyte(output logic [7:0] b, input logic ack);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      b = {b[6:0], r};
    end
    bit_io(!ack, r);
  endtask : rbyte
endmodule : ics_bus_master_model

// ---- sim/ics_clock_stretch_chk.sv ----
// port-level assertions for the clock-stretch block
// assumes it is bound to ics_clock_stretch and sees its ports only
`include "ics_regs.svh"
module ics_clock_stretch_chk (
  input wire logic               i_ref_clk,
  input wire logic               i_rstn,
  input wire ics_pkg::ics_addr_t i_avs_address,
  input wire logic               i_avs_read,
  input wire logic               i_avs_write,
  input wire ics_pkg::ics_word_t i_avs_writedata,
  input wire logic [3:0]         i_avs_byteenable,
  input wire ics_pkg::ics_word_t o_avs_readdata,
  input wire logic               o_avs_waitrequest,
  input wire logic               i_scl_in,
  input wire logic               o_scl_out,
  input wire logic               o_scl_oe,
  input wire logic               o_sda_out,
  input wire logic               o_sda_oe,
  input wire logic               o_tx_buffer_full,
  input wire logic               o_rx_buffer_full,
  input wire logic               o_clock_release_ctl
);
  import ics_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  wire acc_ok  = !o_avs_waitrequest;
  wire wr_ctrl = i_avs_write && acc_ok && i_avs_address == `ICS_OFS_CTRL && i_avs_byteenable[0];
  wire wr_tx   = i_avs_write && acc_ok && i_avs_address == `ICS_OFS_TX_DATA && i_avs_byteenable[0];
  wire rd_rx   = i_avs_read && acc_ok && i_avs_address == `ICS_OFS_RX_DATA;

  scl_pull_only_a: assert property (!o_scl_out)
    else $error("scl driven high");
  sda_pull_only_a: assert property (o_sda_oe |-> !o_sda_out)
    else $error("sda driven high");
  sw_set_release_a: assert property (wr_ctrl && i_avs_writedata[0] |=> o_clock_release_ctl)
    else $error("software set of release lost");
  release_frees_scl_a: assert property (o_clock_release_ctl |=> !o_scl_oe)
    else $error("scl held after release");
  hold_until_set_a: assert property (o_scl_oe && !o_clock_release_ctl |=> o_scl_oe)
    else $error("scl hold dropped early");
  hold_needs_clear_a: assert property ($rose(o_scl_oe) |-> !$past(o_clock_release_ctl))
    else $error("scl pulled with release set");
  pull_when_low_a: assert property ((!o_clock_release_ctl && !i_scl_in) [*5] |=> o_scl_oe)
    else $error("scl not pulled while low");
  tx_load_full_a: assert property (wr_tx |=> o_tx_buffer_full)
    else $error("tx full flag not set");
  rx_read_empty_a: assert property (rd_rx && o_rx_buffer_full |=> !o_rx_buffer_full)
    else $error("rx full flag not cleared");

  cover property ($rose(o_scl_oe));
  cover property (rd_rx);
  cover property (wr_ctrl && !i_avs_writedata[0]);
endmodule : ics_clock_stretch_chk

bind ics_clock_stretch ics_clock_stretch_chk ics_clock_stretch_chk_inst (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_scl_in(i_scl_in), .o_scl_out(o_scl_out),
  .o_scl_oe(o_scl_oe), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_tx_buffer_full(o_tx_buffer_full), .o_rx_buffer_full(o_rx_buffer_full),
  .o_clock_release_ctl(o_clock_release_ctl));

// ---- sim/ics_clock_stretch_test.sv ----
// self-checking bench: avalon master, bus master model, read scoreboard
// assumes pull-ups on scl and sda, resolved here from all enables
`include "ics_regs.svh"
module ics_clock_stretch_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ics_pkg::*;
  logic       clk = 1'b0, rstn = 1'b0, av_read, av_write, master_done, wreq, irq;
  logic       scl_out, scl_oe, sda_out, sda_oe, txf, rxf, rel, m_scl_low, m_sda_low, ack;
  ics_addr_t  av_address;
  ics_word_t  av_wdata, rdata;
  logic [3:0] av_be;
  logic [9:0] own;
  ics_byte_t  d[5], got;
  ics_word_t  exp_q[$];
  int         errors = 0, compares = 0, cycles = 0, n;
  wire        scl = !(m_scl_low || scl_oe);
  wire        sda = !(m_sda_low || sda_oe);

  ics_clock_stretch ics_clock_stretch_inst (.i_ref_clk(clk), .i_rstn(rstn),
    .i_avs_address(av_address), .i_avs_read(av_read), .i_avs_write(av_write),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_scl_in(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_master_done(master_done),
    .o_irq(irq), .o_tx_buffer_full(txf), .o_rx_buffer_full(rxf), .o_clock_release_ctl(rel));
  ics_bus_master_model ics_bus_master_model_inst (.i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));

  initial begin
    forever #5 clk = ~clk;
  end

  task test_done();
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task chk(input string what, input ics_word_t seen, input ics_word_t exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // the run is under two thousand cycles; this ceiling only cuts a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      test_done();
    end
  end

  // read data is taken only at the edge where waitrequest is seen low
  always @(posedge clk) begin
    if (av_read === 1'b1 && wreq === 1'b0) chk("read data", rdata, exp_q.pop_front());
  end

  task wr(input ics_addr_t a, input ics_word_t v);
    @(posedge clk);
    av_address <= a;
    av_wdata <= v;
    av_write <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    av_write <= 1'b0;
  endtask : wr

  task rd(input ics_addr_t a, input ics_word_t e);
    exp_q.push_back(e);
    @(posedge clk);
    av_address <= a;
    av_read <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    av_read <= 1'b0;
  endtask : rd

  task hold_wait(input logic v);
    for (n = 0; n < 40 && scl_oe !== v; n++) @(posedge clk);
    chk("scl hold", scl_oe, v);
  endtask : hold_wait

  task pulse_done();
    @(posedge clk) master_done <= 1'b1;
    @(posedge clk) master_done <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_done

  initial begin
    {av_read, av_write, master_done, av_address, av_wdata} = '0;
    av_be = 4'hf;
    void'($urandom(32'hd5008eef));
    foreach (d[i]) d[i] = 8'($urandom);
    own = {3'h0, 7'h10 + 7'($urandom % 96)};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("release after reset", rel, 1'b1);
    rd(`ICS_OFS_CTRL, 32'h1);
    rd(5'h1c, 32'h0);
    wr(`ICS_OFS_IRQ_MASK, 32'h3);
    wr(`ICS_OFS_OWN_ADDR, {22'h0, own});
    wr(`ICS_OFS_CTRL, 32'hb);
    pulse_done();
    chk("irq", irq, 1'b1);
    rd(`ICS_OFS_IRQ_STAT, 32'h1);
    rd(`ICS_OFS_IRQ_STAT, 32'h0);
    wr(`ICS_OFS_IRQ_MASK, 32'h2);
    pulse_done();
    chk("masked irq", irq, 1'b0);
    rd(`ICS_OFS_IRQ_STAT, 32'h1);
    wr(`ICS_OFS_IRQ_MASK, 32'h3);
    // 7-bit receive with stretching on
    ics_bus_master_model_inst.start();
    ics_bus_master_model_inst.wbyte({own[6:0], 1'b0}, ack);
    chk("address ack", ack, 1'b1);
    rd(`ICS_OFS_IRQ_STAT, 32'h2);
    ics_bus_master_model_inst.wbyte(d[0], ack);
    hold_wait(1'b1);
    chk("release", rel, 1'b0);
    chk("rx full", rxf, 1'b1);
    rd(`ICS_OFS_STATUS, 32'h6);
    rd(`ICS_OFS_IRQ_STAT, 32'h8);
    rd(`ICS_OFS_RX_DATA, {24'h0, d[0]});
    wr(`ICS_OFS_CTRL, 32'hb);
    hold_wait(1'b0);
    fork
      ics_bus_master_model_inst.wbyte(d[1], ack);
      begin
        for (n = 0; n < 300 && rxf !== 1'b1; n++) @(posedge clk);
        rd(`ICS_OFS_RX_DATA, {24'h0, d[1]});
      end
    join
    repeat (8) @(posedge clk);
    chk("release", rel, 1'b1);
    chk("scl hold", scl_oe, 1'b0);
    // software clear while scl is already low
    wr(`ICS_OFS_CTRL, 32'ha);
    hold_wait(1'b1);
    wr(`ICS_OFS_CTRL, 32'hb);
    hold_wait(1'b0);
    ics_bus_master_model_inst.stop();
    // 10-bit receive
    own = 10'($urandom);
    wr(`ICS_OFS_OWN_ADDR, {22'h0, own});
    wr(`ICS_OFS_CTRL, 32'hf);
    ics_bus_master_model_inst.start();
    ics_bus_master_model_inst.wbyte({5'b11110, own[9:8], 1'b0}, ack);
    chk("header ack", ack, 1'b1);
    ics_bus_master_model_inst.wbyte(own[7:0], ack);
    chk("low address ack", ack, 1'b1);
    ics_bus_master_model_inst.wbyte(d[2], ack);
    hold_wait(1'b1);
    rd(`ICS_OFS_RX_DATA, {24'h0, d[2]});
    wr(`ICS_OFS_CTRL, 32'hf);
    hold_wait(1'b0);
    ics_bus_master_model_inst.stop();
    // 7-bit transmit with stretch_enable off; transmit still stretches scl
    wr(`ICS_OFS_OWN_ADDR, {25'h0, own[6:0]});
    wr(`ICS_OFS_CTRL, 32'h9);
    wr(`ICS_OFS_CTRL, 32'h8);
    // the write lands at the edge wr returns on; look one edge later
    @(posedge clk);
    chk("release kept", rel, 1'b1);
    ics_bus_master_model_inst.start();
    ics_bus_master_model_inst.wbyte({own[6:0], 1'b1}, ack);
    chk("read address ack", ack, 1'b1);
    hold_wait(1'b1);
    chk("release", rel, 1'b0);
    wr(`ICS_OFS_TX_DATA, {24'h0, d[3]});
    wr(`ICS_OFS_CTRL, 32'h9);
    fork
      ics_bus_master_model_inst.rbyte(got, 1'b1);
      begin
        for (n = 0; n < 300 && txf !== 1'b0; n++) @(posedge clk);
        wr(`ICS_OFS_TX_DATA, {24'h0, d[4]});
      end
    join
    chk("tx byte", got, d[3]);
    repeat (8) @(posedge clk);
    chk("release", rel, 1'b1);
    chk("scl hold", scl_oe, 1'b0);
    chk("tx full", txf, 1'b0);
    ics_bus_master_model_inst.rbyte(got, 1'b0);
    chk("tx byte", got, d[4]);
    ics_bus_master_model_inst.stop();
    test_done();
  end
endmodule : ics_clock_stretch_test

// ---- verilog/ics_clock_stretch.sv ----
// slave clock stretching and event flags of a two-wire bus controller
// assumes an external master drives scl; pins are open drain with pull-ups
// registers are reached over avalon-mm with waitrequest
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`include "ics_regs.svh"

module ics_clock_stretch (
  // clock and reset
  input  wire logic               i_ref_clk,
  input  wire logic               i_rstn,
  // avalon-mm slave
  input  wire ics_pkg::ics_addr_t i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire ics_pkg::ics_word_t i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output ics_pkg::ics_word_t      o_avs_readdata,
  output logic                    o_avs_waitrequest,
  // two-wire bus pins
  input  wire logic               i_scl_in,
  output logic                    o_scl_out,
  output logic                    o_scl_oe,
  input  wire logic               i_sda_in,
  output logic                    o_sda_out,
  output logic                    o_sda_oe,
  // controller side
  input  wire logic               i_master_done,
  output logic                    o_irq,
  output logic                    o_tx_buffer_full,
  output logic                    o_rx_buffer_full,
  output logic                    o_clock_release_ctl
);

  import ics_pkg::*;

  function automatic logic hit(input ics_addr_t a, input ics_addr_t ofs);
    return a == ofs;
  endfunction : hit

  logic       [1:0] pin_s;
  logic             scl_d;
  logic             sda_d;
  logic             clock_release_ctl;
  logic             stretch_enable;
  logic             ten_bit_mode;
  logic             bus_enable;
  logic       [9:0] own_addr;
  ics_byte_t        tx_data_reg;
  ics_byte_t        rx_data_reg;
  ics_byte_t        rx_sh;
  ics_byte_t        tx_sh;
  logic             tx_buffer_full;
  logic             rx_buffer_full;
  logic             rw;
  logic             ack_ours;
  logic             want_lo;
  logic             ack_in;
  logic             ten_hit;
  logic             got_rise;
  logic       [3:0] bitcnt;
  logic             sda_oe;
  logic             scl_hold;
  logic             drive_low;
  logic             wait_q;
  ics_word_t        rdata;
  ics_irq_t         irq_stat;
  ics_irq_t         irq_mask;
  logic             irq;
  ics_state_t       state;
  ics_state_t       next_state;
  logic             next_release;
  logic             next_hold;

  ics_pin_sync #(
    .W (2)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_pins    ({i_scl_in, i_sda_in}),
    .o_level   (pin_s)
  );

  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];

  // bus conditions seen through the synchronisers
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start    = scl_s & scl_d & sda_d & ~sda_s;
  wire stop     = scl_s & scl_d & ~sda_d & sda_s;

  // avalon decode: a request is answered in the cycle after it is seen
  wire req      = i_avs_read | i_avs_write;
  wire take     = req & ~wait_q;
  wire wr_take  = i_avs_write & take;
  wire rd_take  = i_avs_read & take;
  wire be0      = i_avs_byteenable[0];
  wire be1      = i_avs_byteenable[1];
  wire wr_ctrl  = wr_take & be0 & hit(i_avs_address, `ICS_OFS_CTRL);
  wire wr_alo   = wr_take & be0 & hit(i_avs_address, `ICS_OFS_OWN_ADDR);
  wire wr_ahi   = wr_take & be1 & hit(i_avs_address, `ICS_OFS_OWN_ADDR);
  wire wr_tx    = wr_take & be0 & hit(i_avs_address, `ICS_OFS_TX_DATA);
  wire wr_mask  = wr_take & be0 & hit(i_avs_address, `ICS_OFS_IRQ_MASK);
  wire rd_rx    = rd_take & hit(i_avs_address, `ICS_OFS_RX_DATA);
  wire rd_irq   = rd_take & hit(i_avs_address, `ICS_OFS_IRQ_STAT);
  wire [31:0] wd = i_avs_writedata;

  // byte framing
  wire in_xfer   = state != st_idle;
  wire bit_fall  = scl_fall & got_rise & in_xfer;
  wire last_fall = bit_fall & (bitcnt == `ICS_LAST_DATA);
  wire ack_fall  = bit_fall & (bitcnt == `ICS_ACK_BIT);
  wire in_addr   = state == st_addr;
  wire in_addr2  = state == st_addr2;
  wire in_rx     = state == st_rx;
  wire in_tx     = state == st_tx;

  // address match; the whole 10-bit address sits in own_addr
  wire hdr10     = (rx_sh[7:3] == `ICS_TEN_HDR) & (rx_sh[2:1] == own_addr[9:8]);
  wire match7    = ~ten_bit_mode & (rx_sh[7:1] == own_addr[6:0]);
  wire match10_w = ten_bit_mode & hdr10 & ~rx_sh[0];
  wire match10_r = ten_bit_mode & hdr10 & rx_sh[0] & ten_hit;
  wire addr_ok   = match7 | match10_w | match10_r;
  wire lo_ok     = rx_sh == own_addr[7:0];
  wire ack_now   = (in_addr & addr_ok) | (in_addr2 & lo_ok) | (in_rx & ~rx_buffer_full);

  // data movement
  wire rx_store  = last_fall & in_rx & ~rx_buffer_full;
  wire rx_over   = last_fall & in_rx & rx_buffer_full;
  wire slv_ev    = last_fall & ((in_addr & addr_ok & ~match10_w) | (in_addr2 & lo_ok));
  wire addr_rd   = in_addr & ack_ours & ~want_lo & rw;
  wire enter_tx  = ack_fall & (addr_rd | (in_tx & ack_in));
  wire tx_load   = (state == st_tx_load) & tx_buffer_full;

  // stretch decisions at the ninth falling edge, or on a software write to the release bit
  wire tx_stretch = enter_tx & ~tx_buffer_full;
  wire rx_stretch = ack_fall & in_rx & ack_ours & stretch_enable & rx_buffer_full;
  wire sw_set     = wr_ctrl & wd[`ICS_CTRL_RELEASE];
  wire sw_clr     = wr_ctrl & ~wd[`ICS_CTRL_RELEASE] & stretch_enable;

  wire [31:0] ctrl_word = {28'h0, bus_enable, ten_bit_mode, stretch_enable, clock_release_ctl};
  wire [31:0] stat_word = {27'h0, ten_hit, in_tx, scl_hold, rx_buffer_full, tx_buffer_full};
  wire [31:0] rd_mux =
    hit(i_avs_address, `ICS_OFS_CTRL)     ? ctrl_word :
    hit(i_avs_address, `ICS_OFS_OWN_ADDR) ? {22'h0, own_addr} :
    hit(i_avs_address, `ICS_OFS_TX_DATA)  ? {24'h0, tx_data_reg} :
    hit(i_avs_address, `ICS_OFS_RX_DATA)  ? {24'h0, rx_data_reg} :
    hit(i_avs_address, `ICS_OFS_STATUS)   ? stat_word :
    hit(i_avs_address, `ICS_OFS_IRQ_STAT) ? {28'h0, irq_stat} :
    hit(i_avs_address, `ICS_OFS_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0;

  // a status read clears only the bits it returned, so later events survive
  wire [3:0] irq_clr = rd_irq ? rdata[3:0] : 4'h0;
  wire [3:0] irq_ev;
  assign irq_ev[`ICS_IRQ_MASTER] = i_master_done;
  assign irq_ev[`ICS_IRQ_SLAVE]  = slv_ev;
  assign irq_ev[`ICS_IRQ_OVFL]   = rx_over;
  assign irq_ev[`ICS_IRQ_HOLD]   = next_hold & ~scl_hold;

  // set wins over any clear so a software set is never lost
  assign next_release = sw_set ? 1'b1 :
                        (tx_stretch | rx_stretch | sw_clr) ? 1'b0 : clock_release_ctl;

  // the pull waits for scl to be sampled low, so a clear never cuts a high phase
  assign next_hold = ~clock_release_ctl & (scl_hold | ~scl_s);

  always_comb begin
    next_state = state;
    if (!bus_enable || stop) begin
      next_state = st_idle;
    end else if (start) begin
      next_state = st_addr;
    end else begin
      case (state)
        st_addr: begin
          if (ack_fall) begin
            if (!ack_ours) begin
              next_state = st_idle;
            end else if (want_lo) begin
              next_state = st_addr2;
            end else if (rw) begin
              next_state = st_tx_load;
            end else begin
              next_state = st_rx;
            end
          end
        end
        st_addr2: begin
          if (ack_fall) begin
            next_state = ack_ours ? st_rx : st_idle;
          end
        end
        st_rx: begin
          if (ack_fall && !ack_ours) begin
            next_state = st_idle;
          end
        end
        st_tx: begin
          if (ack_fall) begin
            next_state = ack_in ? st_tx_load : st_idle;
          end
        end
        st_tx_load: begin
          if (tx_buffer_full) begin
            next_state = st_tx;
          end
        end
        default: begin
          next_state = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= st_idle;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      state <= next_state;
    end
  end

  // bit counter: a fall only counts once the bit has seen its rise
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || start || !in_xfer) begin
      bitcnt   <= 4'h0;
      got_rise <= 1'b0;
    end else if (bit_fall) begin
      bitcnt   <= ack_fall ? 4'h0 : bitcnt + 4'h1;
      got_rise <= 1'b0;
    end else if (scl_rise) begin
      got_rise <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rx_sh    <= 8'h00;
      ack_in   <= 1'b0;
      ack_ours <= 1'b0;
      rw       <= 1'b0;
      want_lo  <= 1'b0;
    end else begin
      if (scl_rise && (in_addr || in_addr2 || in_rx)) begin
        rx_sh <= {rx_sh[6:0], sda_s};
      end
      if (scl_rise && in_tx && bitcnt == `ICS_ACK_BIT) begin
        ack_in <= ~sda_s;
      end
      if (last_fall) begin
        ack_ours <= ack_now;
        rw       <= rx_sh[0];
        want_lo  <= match10_w;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !bus_enable || stop) begin
      ten_hit <= 1'b0;
    end else if (ack_fall && in_addr2 && ack_ours) begin
      ten_hit <= 1'b1;
    end
  end

  // sda: ack slot, then transmit bits changed only while scl is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !bus_enable || start || stop) begin
      sda_oe <= 1'b0;
    end else if (last_fall) begin
      sda_oe <= ack_now;
    end else if (ack_fall) begin
      sda_oe <= 1'b0;
    end else if (tx_load) begin
      sda_oe <= ~tx_data_reg[7];
    end else if (bit_fall && in_tx) begin
      sda_oe <= ~tx_sh[6];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tx_sh <= 8'h00;
    end else if (tx_load) begin
      tx_sh <= tx_data_reg;
    end else if (bit_fall && in_tx) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      tx_data_reg    <= 8'h00;
      tx_buffer_full <= 1'b0;
    end else if (wr_tx) begin
      tx_data_reg    <= wd[7:0];
      tx_buffer_full <= 1'b1;
    end else if (tx_load) begin
      tx_buffer_full <= 1'b0;
    end
  end

  // an overflowing byte is refused with a nack and the held byte is kept
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rx_data_reg    <= 8'h00;
      rx_buffer_full <= 1'b0;
    end else if (rx_store) begin
      rx_data_reg    <= rx_sh;
      rx_buffer_full <= 1'b1;
    end else if (rd_rx) begin
      rx_buffer_full <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      clock_release_ctl <= `ICS_RELEASE_RST;
      scl_hold          <= 1'b0;
    end else begin
      clock_release_ctl <= next_release;
      scl_hold          <= next_hold;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      stretch_enable <= 1'b0;
      ten_bit_mode   <= 1'b0;
      bus_enable     <= 1'b0;
      own_addr       <= `ICS_ADDR_RST;
      irq_mask       <= `ICS_IRQ_RST;
    end else begin
      if (wr_ctrl) begin
        stretch_enable <= wd[`ICS_CTRL_STRETCH];
        ten_bit_mode   <= wd[`ICS_CTRL_TENBIT];
        bus_enable     <= wd[`ICS_CTRL_ENABLE];
      end
      if (wr_alo) begin
        own_addr[7:0] <= wd[7:0];
      end
      if (wr_ahi) begin
        own_addr[9:8] <= wd[9:8];
      end
      if (wr_mask) begin
        irq_mask <= wd[3:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      irq_stat <= `ICS_IRQ_RST;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq      <= |(irq_stat & irq_mask);
    end
  end

  // read data is caught in the waiting cycle and stands through the answer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wait_q    <= 1'b1;
      rdata     <= 32'h0;
      drive_low <= 1'b0;
    end else begin
      wait_q    <= ~(req & wait_q);
      drive_low <= 1'b0;
      if (i_avs_read && wait_q) begin
        rdata <= rd_mux;
      end
    end
  end

  assign o_avs_readdata      = rdata;
  assign o_avs_waitrequest   = wait_q;
  assign o_scl_out           = drive_low;
  assign o_scl_oe            = scl_hold;
  assign o_sda_out           = drive_low;
  assign o_sda_oe            = sda_oe;
  assign o_irq               = irq;
  assign o_tx_buffer_full    = tx_buffer_full;
  assign o_rx_buffer_full    = rx_buffer_full;
  assign o_clock_release_ctl = clock_release_ctl;

endmodule : ics_clock_stretch

// ---- verilog/ics_pin_sync.sv ----
// two-flop synchronisers for the bus pins
// assumes pins idle high (pull-ups), so the flops reset to one
module ics_pin_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  // raw pins and synchronised levels
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] meta;

  for (genvar g = 0; g < W; g++) begin : g_sync
    always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
        meta[g]    <= 1'b1;
        o_level[g] <= 1'b1;
      end else begin
        meta[g]    <= i_pins[g];
        o_level[g] <= meta[g];
      end
    end
  end

endmodule : ics_pin_sync

// ---- verilog/ics_pkg.sv ----
// types shared by the clock-stretch block
// assumes ics_regs.svh carries all numeric constants
package ics_pkg;

  typedef logic [31:0] ics_word_t;
  typedef logic [4:0]  ics_addr_t;
  typedef logic [7:0]  ics_byte_t;
  typedef logic [3:0]  ics_irq_t;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr2,
    st_rx,
    st_tx,
    st_tx_load
  } ics_state_t;

endpackage : ics_pkg

// ---- verilog/ics_regs.svh ----
// register map, field positions and reset values of the clock-stretch block
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef ICS_REGS_SVH
`define ICS_REGS_SVH

// byte offsets
`define ICS_OFS_CTRL      5'h00
`define ICS_OFS_OWN_ADDR  5'h04
`define ICS_OFS_TX_DATA   5'h08
`define ICS_OFS_RX_DATA   5'h0c
`define ICS_OFS_STATUS    5'h10
`define ICS_OFS_IRQ_STAT  5'h14
`define ICS_OFS_IRQ_MASK  5'h18

// bus_control_reg fields
`define ICS_CTRL_RELEASE  0
`define ICS_CTRL_STRETCH  1
`define ICS_CTRL_TENBIT   2
`define ICS_CTRL_ENABLE   3

// event bits in irq status and mask
`define ICS_IRQ_MASTER    0
`define ICS_IRQ_SLAVE     1
`define ICS_IRQ_OVFL      2
`define ICS_IRQ_HOLD      3

// reset values
`define ICS_RELEASE_RST   1'b1
`define ICS_ADDR_RST      10'h000
`define ICS_IRQ_RST       4'h0

// bit positions within one byte transfer and the 10-bit address header
`define ICS_LAST_DATA     4'h7
`define ICS_ACK_BIT       4'h8
`define ICS_TEN_HDR       5'h1e

`endif
